// *** src/usb_iso_pkg.sv ***
package usb_iso_pkg;

	// ****************************************
	// bus geometry
	// ****************************************
	localparam int ADDR_W = 8;                       // register address width
	localparam int DATA_W = 32;                      // bus data width
	localparam int BYTE_W = 8;                       // one packet byte
	localparam int STRB_W = DATA_W / 8;              // byte enables

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00; // enable, mode, interrupt enables
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04; // endpoint_status_reg
	localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h08; // byte_count_low_reg
	localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h0C; // byte_count_high_reg
	localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h10; // buffer read port

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_EN  = 0;                     // endpoint enabled and configured
	localparam int CTRL_PP  = 1;                     // two-bank mode
	localparam int CTRL_IE0 = 2;                     // bank 0 interrupt enable
	localparam int CTRL_IE1 = 3;                     // bank 1 interrupt enable
	localparam int CTRL_W   = 4;                     // control field width
	localparam int ST_B0    = 0;                     // out_bank0_received_flag
	localparam int ST_B1    = 1;                     // out_bank1_received_flag
	localparam int ST_CRC   = 2;                     // crc_error_flag
	localparam int ST_RXB   = 3;                     // bank the host fills next
	localparam int ST_FWB   = 4;                     // bank firmware reads

	// ****************************************
	// reset values and answers
	// ****************************************
	localparam logic [CTRL_W-1:0] CTRL_RST    = 4'h0;
	localparam logic [1:0]        RESP_OKAY   = 2'h0;
	localparam logic [1:0]        RESP_SLVERR = 2'h2;
	localparam int                BUF_DEPTH   = 64;  // bytes per bank
	localparam int                CNT_W       = 16;  // low and high count bytes

	// receive sequencer states
	typedef enum logic [0:0] {
		RX_IDLE = 1'b0,
		RX_DATA = 1'b1
	} rx_state_t;

	// true for a mapped register address
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_CNT_LO) ||
			(a == OFS_CNT_HI) || (a == OFS_DATA);
	endfunction

endpackage

// *** src/usb_iso_bank_mem.sv ***
`timescale 1ns/1ps
module usb_iso_bank_mem #(
	parameter int DEPTH = usb_iso_pkg::BUF_DEPTH,
	parameter int IDX_W = $clog2(usb_iso_pkg::BUF_DEPTH)
) (
	input  wire logic                           sys_clk_in,
	input  wire logic                           wr_en_in,
	input  wire logic                           wr_bank_in,
	input  wire logic [IDX_W-1:0]               wr_idx_in,
	input  wire logic [usb_iso_pkg::BYTE_W-1:0] wr_byte_in,
	input  wire logic                           rd_bank_in,
	input  wire logic [IDX_W-1:0]               rd_idx_in,
	output logic      [usb_iso_pkg::BYTE_W-1:0] rd_byte_out
);
	import usb_iso_pkg::*;

	// ****************************************
	// two banks of flip-flop storage
	// ****************************************
	logic [BYTE_W-1:0] mem_q [2][DEPTH];             // bank, entry

	// one write port, one entry per generate step
	for (genvar b = 0; b < 2; b++) begin : g_bank
		for (genvar e = 0; e < DEPTH; e++) begin : g_ent
			always_ff @(posedge sys_clk_in) begin
				if (wr_en_in && (wr_bank_in == 1'(b)) && (wr_idx_in == IDX_W'(e))) begin
					mem_q[b][e] <= wr_byte_in;
				end
			end
		end
	end

	// read port is combinational
	assign rd_byte_out = mem_q[rd_bank_in][rd_idx_in];

endmodule

// *** src/usb_iso_axil_slave.sv ***
`timescale 1ns/1ps
module usb_iso_axil_slave (
	input  wire logic                           sys_clk_in,
	input  wire logic                           rst_n_in,
	input  wire logic [usb_iso_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                           s_axi_awvalid_in,
	output logic                                s_axi_awready_out,
	input  wire logic [usb_iso_pkg::DATA_W-1:0] s_axi_wdata_in,
	input  wire logic [usb_iso_pkg::STRB_W-1:0] s_axi_wstrb_in,
	input  wire logic                           s_axi_wvalid_in,
	output logic                                s_axi_wready_out,
	output logic [1:0]                          s_axi_bresp_out,
	output logic                                s_axi_bvalid_out,
	input  wire logic                           s_axi_bready_in,
	input  wire logic [usb_iso_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                           s_axi_arvalid_in,
	output logic                                s_axi_arready_out,
	output logic [usb_iso_pkg::DATA_W-1:0]      s_axi_rdata_out,
	output logic [1:0]                          s_axi_rresp_out,
	output logic                                s_axi_rvalid_out,
	input  wire logic                           s_axi_rready_in,
	output logic                                reg_wr_out,
	output logic [usb_iso_pkg::ADDR_W-1:0]      reg_waddr_out,
	output logic [usb_iso_pkg::DATA_W-1:0]      reg_wdata_out,
	output logic [usb_iso_pkg::STRB_W-1:0]      reg_wstrb_out,
	output logic                                reg_rd_out,
	input  wire logic [usb_iso_pkg::DATA_W-1:0] reg_rdata_in
);
	import usb_iso_pkg::*;

	// ****************************************
	// write channel state
	// ****************************************
	logic              aw_held_q, aw_held_d;         // address taken, waiting
	logic              w_held_q, w_held_d;           // data taken, waiting
	logic              awready_q, awready_d;
	logic              wready_q, wready_d;
	logic              bvalid_q, bvalid_d;
	logic [1:0]        bresp_q, bresp_d;
	logic              wr_q, wr_d;                   // one-cycle register write
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [STRB_W-1:0] wstrb_q, wstrb_d;
	logic              do_wr;                        // both halves present

	// write next state
	always_comb begin
		aw_held_d = aw_held_q | (s_axi_awvalid_in & awready_q);
		w_held_d  = w_held_q | (s_axi_wvalid_in & wready_q);
		waddr_d   = (s_axi_awvalid_in & awready_q) ? s_axi_awaddr_in : waddr_q;
		wdata_d   = (s_axi_wvalid_in & wready_q) ? s_axi_wdata_in : wdata_q;
		wstrb_d   = (s_axi_wvalid_in & wready_q) ? s_axi_wstrb_in : wstrb_q;
		bvalid_d  = bvalid_q & ~s_axi_bready_in;
		bresp_d   = bresp_q;
		do_wr     = aw_held_d & w_held_d & ~bvalid_q;
		wr_d      = 1'b0;
		if (do_wr) begin
			// response follows both halves, in either order
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			wr_d      = reg_hit(waddr_d);
			bvalid_d  = 1'b1;
			bresp_d   = reg_hit(waddr_d) ? RESP_OKAY : RESP_SLVERR;
		end
		awready_d = ~aw_held_d & ~bvalid_d;
		wready_d  = ~w_held_d & ~bvalid_d;
	end

	// write registers
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			wr_q      <= 1'b0;
			waddr_q   <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			wr_q      <= wr_d;
			waddr_q   <= waddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
		end
	end

	// ****************************************
	// read channel state
	// ****************************************
	logic              arready_q, arready_d;
	logic              rvalid_q, rvalid_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [1:0]        rresp_q, rresp_d;
	logic              ar_take;                      // address accepted now

	// read next state; data captured at the address edge
	always_comb begin
		ar_take   = s_axi_arvalid_in & arready_q;
		rvalid_d  = rvalid_q & ~s_axi_rready_in;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (ar_take) begin
			rvalid_d = 1'b1;
			rdata_d  = reg_hit(s_axi_araddr_in) ? reg_rdata_in : '0;
			rresp_d  = reg_hit(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
		end
		arready_d = ~rvalid_d;
	end

	// read registers
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// outputs
	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out  = wready_q;
	assign s_axi_bvalid_out  = bvalid_q;
	assign s_axi_bresp_out   = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out  = rvalid_q;
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;
	assign reg_wr_out        = wr_q;
	assign reg_waddr_out     = waddr_q;
	assign reg_wdata_out     = wdata_q;
	assign reg_wstrb_out     = wstrb_q;
	assign reg_rd_out        = ar_take & reg_hit(s_axi_araddr_in);

endmodule

// *** src/usb_iso_out_endpoint_rx.sv ***
// Overview of operation
// [RULE1] firmware enables endpoint before any packet stored
// [RULE2] single bank: packet sets bank0 received flag
// [RULE3] set flag raises interrupt when enabled
// [RULE4] byte count shown in low/high registers
// [RULE5] zero-length packet reports count zero
// [RULE6] crc error flag set for corrupted packet
// [RULE7] crc flag refreshed on each new packet
// [RULE8] firmware drains buffer before clearing flag
// [RULE9] single bank: data lost while flag set
// [RULE10] clear mid-packet stores only remaining bytes
// [RULE11] overflow bytes dropped, packet still valid
// [RULE12] two banks: bank0 packet sets bank0 flag
// [RULE13] clearing bank0 flag releases and swaps banks
// [RULE14] two banks: bank0 data lost while set
// [RULE15] bank0 released mid-packet stores remaining bytes
// [RULE16] two banks: bank1 packet sets bank1 flag
// [RULE17] firmware drains bank1 before clearing flag
// [RULE18] two banks: bank1 data lost while set
// [RULE19] bank flags set alternately per packet
// [RULE20] firmware clears only the drained bank's flag
// [RULE21] isochronous out never returns a handshake
`timescale 1ns/1ps
module usb_iso_out_endpoint_rx #(
	parameter int DEPTH = usb_iso_pkg::BUF_DEPTH
) (
	input  wire logic                           sys_clk_in,
	input  wire logic                           rst_n_in,
	input  wire logic [usb_iso_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                           s_axi_awvalid_in,
	output logic                                s_axi_awready_out,
	input  wire logic [usb_iso_pkg::DATA_W-1:0] s_axi_wdata_in,
	input  wire logic [usb_iso_pkg::STRB_W-1:0] s_axi_wstrb_in,
	input  wire logic                           s_axi_wvalid_in,
	output logic                                s_axi_wready_out,
	output logic [1:0]                          s_axi_bresp_out,
	output logic                                s_axi_bvalid_out,
	input  wire logic                           s_axi_bready_in,
	input  wire logic [usb_iso_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                           s_axi_arvalid_in,
	output logic                                s_axi_arready_out,
	output logic [usb_iso_pkg::DATA_W-1:0]      s_axi_rdata_out,
	output logic [1:0]                          s_axi_rresp_out,
	output logic                                s_axi_rvalid_out,
	input  wire logic                           s_axi_rready_in,
	input  wire logic                           pkt_start_in,
	input  wire logic                           pkt_byte_valid_in,
	input  wire logic [usb_iso_pkg::BYTE_W-1:0] pkt_byte_in,
	input  wire logic                           pkt_end_in,
	input  wire logic                           pkt_crc_ok_in,
	output logic                                ep_irq_out,
	output logic                                handshake_send_out
);
	import usb_iso_pkg::*;

	localparam int IDX_W = $clog2(DEPTH);            // buffer index width
	localparam int PTR_W = IDX_W + 1;                // index plus full count

	// ****************************************
	// register bus wiring
	// ****************************************
	logic              reg_wr;                       // write strobe
	logic [ADDR_W-1:0] reg_waddr;                    // write address
	logic [DATA_W-1:0] reg_wdata;                    // write data
	logic [STRB_W-1:0] reg_wstrb;                    // write byte enables
	logic              reg_rd;                       // read strobe, pops data
	logic [DATA_W-1:0] reg_rdata;                    // read mux
	logic [BYTE_W-1:0] mem_rd_byte;                  // byte at read pointer

	// bus slave
	usb_iso_axil_slave u_bus (
		.sys_clk_in        (sys_clk_in),
		.rst_n_in          (rst_n_in),
		.s_axi_awaddr_in   (s_axi_awaddr_in),
		.s_axi_awvalid_in  (s_axi_awvalid_in),
		.s_axi_awready_out (s_axi_awready_out),
		.s_axi_wdata_in    (s_axi_wdata_in),
		.s_axi_wstrb_in    (s_axi_wstrb_in),
		.s_axi_wvalid_in   (s_axi_wvalid_in),
		.s_axi_wready_out  (s_axi_wready_out),
		.s_axi_bresp_out   (s_axi_bresp_out),
		.s_axi_bvalid_out  (s_axi_bvalid_out),
		.s_axi_bready_in   (s_axi_bready_in),
		.s_axi_araddr_in   (s_axi_araddr_in),
		.s_axi_arvalid_in  (s_axi_arvalid_in),
		.s_axi_arready_out (s_axi_arready_out),
		.s_axi_rdata_out   (s_axi_rdata_out),
		.s_axi_rresp_out   (s_axi_rresp_out),
		.s_axi_rvalid_out  (s_axi_rvalid_out),
		.s_axi_rready_in   (s_axi_rready_in),
		.reg_wr_out        (reg_wr),
		.reg_waddr_out     (reg_waddr),
		.reg_wdata_out     (reg_wdata),
		.reg_wstrb_out     (reg_wstrb),
		.reg_rd_out        (reg_rd),
		.reg_rdata_in      (reg_rdata)
	);

	// ****************************************
	// endpoint state
	// ****************************************
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;               // enable, mode, interrupt enables
	logic [1:0]        flag_q, flag_d;               // per-bank received flags
	logic              crc_q, crc_d;                 // crc_error_flag
	logic              rx_bank_q, rx_bank_d;         // bank the host fills next
	logic              fw_bank_q, fw_bank_d;         // bank firmware drains
	logic [PTR_W-1:0]  cnt_q [2];                    // stored byte count per bank
	logic [PTR_W-1:0]  cnt_d [2];
	rx_state_t         st_q, st_d;                   // receive sequencer
	logic              tgt_q, tgt_d;                 // bank of packet in flight
	logic [PTR_W-1:0]  wr_ptr_q, wr_ptr_d;           // next write entry
	logic [PTR_W-1:0]  rd_ptr_q, rd_ptr_d;           // next firmware read entry
	logic              irq_q, irq_d;                 // endpoint interrupt request
	logic              hs_q, hs_d;                   // handshake request
	logic              mem_we;                       // store this byte
	logic [1:0]        clr;                          // firmware clear per bank
	logic              pp;                           // two-bank mode
	logic [CNT_W-1:0]  cnt_show;                     // count seen by firmware

	assign pp = ctrl_q[CTRL_PP];

	// register read mux
	always_comb begin
		cnt_show  = CNT_W'(cnt_q[fw_bank_q]);
		reg_rdata = '0;
		unique case (s_axi_araddr_in)
			OFS_CTRL: begin
				reg_rdata[CTRL_W-1:0] = ctrl_q;
			end
			OFS_STATUS: begin
				reg_rdata[ST_B0]  = flag_q[0];
				reg_rdata[ST_B1]  = flag_q[1];
				reg_rdata[ST_CRC] = crc_q;
				reg_rdata[ST_RXB] = rx_bank_q;
				reg_rdata[ST_FWB] = fw_bank_q;
			end
			OFS_CNT_LO: begin
				reg_rdata[BYTE_W-1:0] = cnt_show[BYTE_W-1:0]; // RULE4
			end
			OFS_CNT_HI: begin
				reg_rdata[BYTE_W-1:0] = cnt_show[CNT_W-1:BYTE_W]; // RULE4
			end
			OFS_DATA: begin
				reg_rdata[BYTE_W-1:0] = mem_rd_byte;
			end
			default: begin
				reg_rdata = '0;
			end
		endcase
	end

	// next values of all endpoint state
	always_comb begin
		ctrl_d    = ctrl_q;
		flag_d    = flag_q;
		crc_d     = crc_q;
		rx_bank_d = rx_bank_q;
		fw_bank_d = fw_bank_q;
		cnt_d     = cnt_q;
		st_d      = st_q;
		tgt_d     = tgt_q;
		wr_ptr_d  = wr_ptr_q;
		rd_ptr_d  = rd_ptr_q;
		hs_d      = 1'b0;
		mem_we    = 1'b0;
		clr       = 2'b00;

		// control write
		if (reg_wr && reg_waddr == OFS_CTRL && reg_wstrb[0]) begin
			ctrl_d = reg_wdata[CTRL_W-1:0];
		end

		// firmware clears a flag by writing one to it
		if (reg_wr && reg_waddr == OFS_STATUS && reg_wstrb[0]) begin
			clr[0] = reg_wdata[ST_B0] & flag_q[0];
			clr[1] = reg_wdata[ST_B1] & flag_q[1] & pp;
		end
		for (int b = 0; b < 2; b++) begin
			if (clr[b]) begin
				flag_d[b] = 1'b0;
				rd_ptr_d  = '0;
				if (pp) begin
					fw_bank_d = ~fw_bank_q; // RULE13
				end
			end
		end

		// firmware pops one byte per data read
		if (reg_rd && s_axi_araddr_in == OFS_DATA && rd_ptr_q < cnt_q[fw_bank_q]) begin
			rd_ptr_d = rd_ptr_q + PTR_W'(1);
		end

		// leaving two-bank mode returns both pointers to bank 0
		if (!ctrl_d[CTRL_PP]) begin
			rx_bank_d = 1'b0;
			fw_bank_d = 1'b0;
			flag_d[1] = 1'b0;
		end

		unique case (st_q)
			RX_IDLE: begin
				// disabled endpoint ignores the host entirely
				if (pkt_start_in && ctrl_q[CTRL_EN]) begin // RULE1
					st_d     = RX_DATA;
					tgt_d    = rx_bank_q;
					wr_ptr_d = '0;
				end
			end
			RX_DATA: begin
				// a byte is kept only while its bank is free
				if (pkt_byte_valid_in && !flag_q[tgt_q]) begin // RULE9 RULE14 RULE18 RULE10 RULE15
					if (wr_ptr_q < PTR_W'(DEPTH)) begin // RULE11
						mem_we   = 1'b1;
						wr_ptr_d = wr_ptr_q + PTR_W'(1);
					end
				end
				if (pkt_end_in) begin
					st_d = RX_IDLE;
					hs_d = 1'b0; // RULE21
					// only a packet that ends in a free bank is recorded
					if (!flag_q[tgt_q] || clr[tgt_q]) begin
						flag_d[tgt_q] = 1'b1; // RULE2 RULE12 RULE16
						cnt_d[tgt_q]  = wr_ptr_d; // RULE4 RULE5
						crc_d         = ~pkt_crc_ok_in; // RULE6 RULE7
						if (pp) begin
							rx_bank_d = ~tgt_q; // RULE19
						end
					end
				end
				if (!ctrl_q[CTRL_EN]) begin
					st_d = RX_IDLE;
				end
			end
			default: begin
				st_d = RX_IDLE;
			end
		endcase

		// interrupt follows enabled flags
		irq_d = (flag_d[0] & ctrl_d[CTRL_IE0]) | (flag_d[1] & ctrl_d[CTRL_IE1]); // RULE3
	end

	// endpoint registers
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ctrl_q    <= CTRL_RST;
			flag_q    <= 2'b00;
			crc_q     <= 1'b0;
			rx_bank_q <= 1'b0;
			fw_bank_q <= 1'b0;
			cnt_q[0]  <= '0;
			cnt_q[1]  <= '0;
			st_q      <= RX_IDLE;
			tgt_q     <= 1'b0;
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			irq_q     <= 1'b0;
			hs_q      <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			flag_q    <= flag_d;
			crc_q     <= crc_d;
			rx_bank_q <= rx_bank_d;
			fw_bank_q <= fw_bank_d;
			cnt_q     <= cnt_d;
			st_q      <= st_d;
			tgt_q     <= tgt_d;
			wr_ptr_q  <= wr_ptr_d;
			rd_ptr_q  <= rd_ptr_d;
			irq_q     <= irq_d;
			hs_q      <= hs_d;
		end
	end

	// ****************************************
	// packet storage
	// ****************************************
	usb_iso_bank_mem #(
		.DEPTH (DEPTH),
		.IDX_W (IDX_W)
	) u_mem (
		.sys_clk_in  (sys_clk_in),
		.wr_en_in    (mem_we),
		.wr_bank_in  (tgt_q),
		.wr_idx_in   (wr_ptr_q[IDX_W-1:0]),
		.wr_byte_in  (pkt_byte_in),
		.rd_bank_in  (fw_bank_q),
		.rd_idx_in   (rd_ptr_q[IDX_W-1:0]),
		.rd_byte_out (mem_rd_byte)
	);

	// outputs straight from flops
	assign ep_irq_out         = irq_q;
	assign handshake_send_out = hs_q;

endmodule

// *** verification/usb_iso_ep_checker.sv ***
`timescale 1ns/1ps
// watches the endpoint's bus and packet ports
module usb_iso_ep_checker (
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [7:0]  s_axi_araddr_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic        pkt_end_in,
	input wire logic        ep_irq_out,
	input wire logic        handshake_send_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// read request taken, and a read answer left waiting
	sequence ar_taken; s_axi_arvalid_in && s_axi_arready_out; endsequence
	sequence r_wait; s_axi_rvalid_out && !s_axi_rready_in; endsequence
	a_no_handshake: assert property (!handshake_send_out) else $error("handshake sent");
	a_read_answer: assert property (ar_taken |=> s_axi_rvalid_out) else $error("read answer late");
	a_read_holds: assert property (r_wait |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read answer dropped");
	a_write_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write answer dropped");
	a_aw_refused: assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
		else $error("second write taken");
	a_unmapped_err: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > 8'h10
		|=> s_axi_rresp_out == 2'h2) else $error("unmapped read not refused");
	a_irq_rise: assert property ($rose(ep_irq_out) |-> $past(pkt_end_in) || $past(s_axi_bvalid_out) ||
		$past(s_axi_bvalid_out, 2)) else $error("irq without cause");
	a_irq_fall: assert property ($fell(ep_irq_out) |-> $past(s_axi_bvalid_out) ||
		$past(s_axi_bvalid_out, 2)) else $error("irq dropped without write");
	a_ready_reset: assert property ($rose(rst_n_in) |-> ##[1:2] s_axi_awready_out && s_axi_arready_out)
		else $error("not ready after reset");
endmodule
bind usb_iso_out_endpoint_rx usb_iso_ep_checker u_chk (.sys_clk_in, .rst_n_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
	.pkt_end_in, .ep_irq_out, .handshake_send_out);

// *** verification/usb_host_model.sv ***
`timescale 1ns/1ps
// host sending isochronous out packets, fast or with a gap per byte
module usb_host_model (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic [7:0] len_in,
	input  wire logic [7:0] seed_in,
	input  wire logic       crc_in,
	input  wire logic       slow_in,
	output logic            start_out,
	output logic            byte_valid_out,
	output logic      [7:0] byte_out,
	output logic            end_out,
	output logic            crc_ok_out,
	output logic            busy_out
);
	int i;
	initial {start_out, byte_valid_out, byte_out, end_out, crc_ok_out, busy_out} = '0;
	// no handshake is awaited after the packet
	always begin
		@(posedge clk_in);
		if (go_in) begin
			busy_out <= 1;
			start_out <= 1;
			@(posedge clk_in);
			start_out <= 0;
			for (i = 0; i < len_in; i++) begin
				if (slow_in) begin
					byte_valid_out <= 0;
					byte_out <= ~byte_out;
					@(posedge clk_in);
				end
				byte_valid_out <= 1;
				byte_out <= seed_in + 8'(i);
				@(posedge clk_in);
			end
			byte_valid_out <= 0;
			byte_out <= ~byte_out;
			end_out <= 1;
			crc_ok_out <= crc_in;
			@(posedge clk_in);
			end_out <= 0;
			busy_out <= 0;
		end else begin
			// idle lines carry junk, inverted each cycle, so the last byte comes back every second cycle
			byte_out <= ~byte_out;
			crc_ok_out <= ~crc_ok_out;
		end
	end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import usb_iso_pkg::*;
	typedef struct {logic [7:0] len; logic crc; logic [31:0] cnt; logic [31:0] st;} row_t;
	logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        go = 0, crc = 1, slow = 0;
	logic [7:0]  awaddr = 0, araddr = 0, len = 0, seed = 0, by;
	logic [31:0] wdata = 0, d, rdata;
	logic [1:0]  rr, br, bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, irq, hs, st, by_v, en, ok, busy;
	int          n_fail = 0, cmp_count = 0, i, c;
	// single-bank rows: length, crc good, expected count and status
	row_t rows[4] = '{'{3, 1, 3, 1}, '{6, 0, 4, 5}, '{0, 1, 0, 1}, '{6, 1, 4, 1}};
	always #5 clk = ~clk;
	usb_iso_out_endpoint_rx #(.DEPTH(4)) u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pkt_start_in(st), .pkt_byte_valid_in(by_v),
		.pkt_byte_in(by), .pkt_end_in(en), .pkt_crc_ok_in(ok), .ep_irq_out(irq), .handshake_send_out(hs));
	usb_host_model u_host (.clk_in(clk), .go_in(go), .len_in(len), .seed_in(seed), .crc_in(crc),
		.slow_in(slow), .start_out(st), .byte_valid_out(by_v), .byte_out(by), .end_out(en),
		.crc_ok_out(ok), .busy_out(busy));
	task automatic report_and_stop;
		$display("compared %0d failed %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			n_fail++;
		end
	endtask
	// bus write: address and data offered together, bready kept high
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin br = bresp; break; end
		end
		if (i == 50) begin n_fail++; report_and_stop(); end
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 0;
			if (rvalid) begin d = rdata; rr = rresp; break; end
		end
		if (i == 50) begin n_fail++; report_and_stop(); end
	endtask
	task automatic rc(input logic [7:0] a, input string n, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
	endtask
	task automatic fire(input logic [7:0] l, input logic [7:0] s, input logic cr, input logic sl);
		len <= l; seed <= s; crc <= cr; slow <= sl; go <= 1;
		@(posedge clk);
		go <= 0;
	endtask
	task automatic done;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (!busy) break;
		end
		if (busy) begin n_fail++; report_and_stop(); end
		repeat (2) @(posedge clk);
	endtask
	task automatic pkt(input logic [7:0] l, input logic [7:0] s);
		fire(l, s, 1, 0);
		done();
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rc(OFS_CTRL, "ctrl reset", 0);
		rc(OFS_STATUS, "status reset", 0);
		rd(8'h20);
		chk("unmapped rresp", 2, rr);
		wr(8'h24, 1);
		chk("unmapped bresp", 2, br);
		pkt(2, 8'h11);
		rc(OFS_STATUS, "disabled status", 0);
		wr(OFS_CTRL, 5);
		foreach (rows[r]) begin
			fire(rows[r].len, 8'h30 + 8'(r), rows[r].crc, r[0]);
			done();
			rc(OFS_STATUS, "row status", rows[r].st);
			chk("row irq", 1, irq);
			rc(OFS_CNT_LO, "row count", rows[r].cnt);
			rc(OFS_CNT_HI, "row count high", 0);
			if (rows[r].cnt != 0) rc(OFS_DATA, "row data", 8'h30 + 8'(r));
			wr(OFS_STATUS, 1);
			rc(OFS_STATUS, "row cleared", rows[r].st - 1);
			chk("row irq off", 0, irq);
		end
		// flag cleared while a slow packet is under way
		pkt(1, 8'h40);
		fire(5, 8'h50, 1, 1);
		repeat (2) @(posedge clk);
		wr(OFS_STATUS, 1);
		done();
		rd(OFS_CNT_LO);
		c = d;
		chk("mid count", 1, c > 0 && c < 5);
		rc(OFS_DATA, "mid data", 8'h55 - c);
		pkt(2, 8'h60);
		rc(OFS_CNT_LO, "lost count", c);
		wr(OFS_STATUS, 1);
		// two banks, interrupt only for bank 1
		wr(OFS_CTRL, 8'hB);
		pkt(2, 8'h70);
		rc(OFS_STATUS, "bank0 set", 9);
		chk("bank0 irq off", 0, irq);
		pkt(3, 8'h80);
		rc(OFS_STATUS, "bank1 set", 3);
		chk("bank1 irq", 1, irq);
		pkt(1, 8'h90);
		rc(OFS_STATUS, "both held", 3);
		rc(OFS_CNT_LO, "bank0 count", 2);
		wr(OFS_STATUS, 1);
		rc(OFS_STATUS, "swapped", 8'h12);
		rc(OFS_CNT_LO, "bank1 count", 3);
		rc(OFS_DATA, "bank1 data", 8'h80);
		pkt(1, 8'hA0);
		pkt(2, 8'hB0);
		rc(OFS_STATUS, "bank1 held", 8'h1B);
		wr(OFS_STATUS, 2);
		rc(OFS_CNT_LO, "refill count", 1);
		rc(OFS_DATA, "refill data", 8'hA0);
		report_and_stop();
	end
endmodule
